// >>> hw/pdpw_pkg.sv
// Constants, types and register map of the per-dot pulse width modulator.
// Assumes one 250 MHz system clock; the dot clock arrives as a pin.
package pdpw_pkg;
  localparam int AXI_AW = 5;
  localparam logic [AXI_AW-1:0] REG_CTRL = 5'h00;
  localparam logic [AXI_AW-1:0] REG_STATUS = 5'h04;
  localparam logic [AXI_AW-1:0] REG_INT_STAT = 5'h08;
  localparam logic [AXI_AW-1:0] REG_INT_CLR = 5'h0C;
  localparam logic [AXI_AW-1:0] REG_INT_EN = 5'h10;
  // Control bits, status fields and interrupt bits.
  localparam int CTRL_RETRACE = 0;
  localparam int CTRL_PWR_REDUCE = 1;
  localparam int ST_DONE = 0;
  localparam int ST_RUNNING = 1;
  localparam int ST_PWR_OK = 2;
  localparam int ST_STEP_LSB = 8;
  localparam int ST_SLOPE_LSB = 16;
  localparam int INT_DONE = 0;
  localparam int INT_TIMEOUT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam logic [1:0] INT_RESET = 2'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Code decoding and ramp geometry.
  localparam logic [7:0] CODE_ZERO = 8'h00;
  localparam logic [7:0] CODE_FULL = 8'hFF;
  localparam logic [8:0] POS_SPAN = 9'h100;
  localparam logic [8:0] POS_CENTRE = 9'h080;
  localparam logic [7:0] OVER_POS = 8'h05;
  localparam int SLOPE_W = 12;
  localparam logic [SLOPE_W-1:0] SLOPE_NOM = 12'h100;
  localparam logic [SLOPE_W-1:0] SLOPE_MIN = 12'h080;
  localparam logic [SLOPE_W-1:0] SLOPE_STEP = 12'h004;
  // Calibration pacing.
  localparam logic [4:0] CAL_DIV_LAST = 5'h1F;
  localparam logic [6:0] CAL_MAX_STEPS = 7'h40;
  localparam logic [11:0] CAL_MAX_DOTS = 12'h800;

  typedef enum logic [1:0] {CAL_IDLE, CAL_HOLD, CAL_RUN} pdpw_cal_t;

  typedef struct packed {
    logic [7:0] code;
    logic single;
    logic lead;
  } pdpw_dot_t;
endpackage : pdpw_pkg

// >>> hw/pdpw_top.sv
// Per-dot pulse width modulator with calibration and an AXI4-Lite register file.
// Assumes pin inputs are asynchronous to I_CLK and the dot clock is much slower than I_CLK.
//
// Local design decisions: the register offsets and the AXI4-Lite register port.
`timescale 1ns/100ps
module pdpw_top import pdpw_pkg::*; (
  input wire logic I_CLK, // System clock, 250 MHz.
  input wire logic I_SYS_RST, // Asynchronous reset, active high.
  input wire logic I_DOT_CLK, // Dot clock pin.
  input wire logic [7:0] I_WIDTH_CODE_BITS, // Width code.
  input wire logic I_SINGLE_OR_DUAL_EDGE_SELECT, // High for single edge.
  input wire logic I_LEADING_OR_TRAILING_EDGE_SELECT, // High for leading edge.
  input wire logic I_RETRACE, // Forces output high.
  input wire logic I_POWER_REDUCE_N, // Low to save power.
  input wire logic I_CAL_REQ, // Calibration request pulse.
  output logic O_PWM, // Modulated output.
  output logic O_CAL_DONE, // Calibration complete.
  output logic O_IRQ, // Level interrupt.
  input wire logic I_S_AWVALID, // Write address valid.
  output logic O_S_AWREADY, // Write address ready.
  input wire logic [AXI_AW-1:0] I_S_AWADDR, // Write address.
  input wire logic I_S_WVALID, // Write data valid.
  output logic O_S_WREADY, // Write data ready.
  input wire logic [31:0] I_S_WDATA, // Write data.
  input wire logic [3:0] I_S_WSTRB, // Write strobes.
  output logic O_S_BVALID, // Write response valid.
  input wire logic I_S_BREADY, // Write response ready.
  output logic [1:0] O_S_BRESP, // Write response.
  input wire logic I_S_ARVALID, // Read address valid.
  output logic O_S_ARREADY, // Read address ready.
  input wire logic [AXI_AW-1:0] I_S_ARADDR, // Read address.
  output logic O_S_RVALID, // Read data valid.
  input wire logic I_S_RREADY, // Read data ready.
  output logic [31:0] O_S_RDATA, // Read data.
  output logic [1:0] O_S_RRESP // Read response.
);

  // Saturating ramp advance; a fast ramp parks at full scale instead of wrapping.
  function automatic logic [15:0] ramp_step(input logic [15:0] r, input logic [SLOPE_W-1:0] s);
    logic [16:0] sum;
    sum = {1'b0, r} + {5'h00, s};
    return sum[16] ? 16'hFFFF : sum[15:0];
  endfunction : ramp_step

  // Level of a partial pulse at ramp position pos for the given placement.
  function automatic logic pulse_level(input pdpw_dot_t d, input logic [7:0] pos);
    logic [8:0] p;
    logic [8:0] c;
    p = {1'b0, pos};
    c = {1'b0, d.code};
    if (d.single && d.lead) begin
      return p >= (POS_SPAN - c);
    end else if (d.single) begin
      return p < c;
    end else begin
      return (p >= (POS_CENTRE - {1'b0, c[8:1]})) && (p < (POS_CENTRE + ((c + 9'h001) >> 1)));
    end
  endfunction : pulse_level

  // Two-stage synchronisers for every pin; the first stage feeds only the second.
  logic [13:0] pin_s1_q;
  logic [13:0] pin_s2_q;
  logic dot_s3_q;
  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      pin_s1_q <= 14'h0000;
      pin_s2_q <= 14'h0000;
      dot_s3_q <= 1'b0;
    end else begin
      pin_s1_q <= {I_DOT_CLK, I_CAL_REQ, I_RETRACE, I_POWER_REDUCE_N,
                   I_SINGLE_OR_DUAL_EDGE_SELECT, I_LEADING_OR_TRAILING_EDGE_SELECT,
                   I_WIDTH_CODE_BITS};
      pin_s2_q <= pin_s1_q;
      dot_s3_q <= pin_s2_q[13];
    end
  end

  logic dot_edge;
  logic cal_req;
  logic retrace;
  logic pwr_ok;
  pdpw_dot_t in_dot;
  logic [1:0] ctrl_q;
  assign dot_edge = pin_s2_q[13] && !dot_s3_q;
  assign cal_req = pin_s2_q[12];
  assign retrace = pin_s2_q[11] || ctrl_q[CTRL_RETRACE];
  assign pwr_ok = pin_s2_q[10] && !ctrl_q[CTRL_PWR_REDUCE];
  assign in_dot = '{code: pin_s2_q[7:0], single: pin_s2_q[9], lead: pin_s2_q[8]};

  // Master and slave latches plus the ramp that measures position within a period.
  pdpw_dot_t stage1_q, stage1_d, stage2_q, stage2_d;
  logic [15:0] ramp_q, ramp_d;
  logic prev_full_q, prev_full_d;
  logic [SLOPE_W-1:0] slope_q;
  logic [7:0] pos;
  logic ramp_full;
  assign pos = ramp_q[15:8];
  assign ramp_full = (pos == CODE_FULL);
  always_comb begin
    stage1_d = stage1_q;
    stage2_d = stage2_q;
    ramp_d = ramp_q;
    prev_full_d = prev_full_q;
    if (dot_edge) begin
      stage1_d = in_dot;
      stage2_d = stage1_q;
      ramp_d = 16'h0000;
      prev_full_d = pwr_ok && (stage2_q.code == CODE_FULL);
    end else if (pwr_ok) begin
      ramp_d = ramp_step(ramp_q, slope_q);
    end
  end
  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      stage1_q <= '0;
      stage2_q <= '0;
      ramp_q <= 16'h0000;
      prev_full_q <= 1'b0;
    end else begin
      stage1_q <= stage1_d;
      stage2_q <= stage2_d;
      ramp_q <= ramp_d;
      prev_full_q <= prev_full_d;
    end
  end

  // Output decode; full-scale codes bypass the ramp compare.
  logic pwm_d;
  always_comb begin
    if (retrace) begin
      pwm_d = 1'b1;
    end else if (!pwr_ok) begin
      pwm_d = 1'b0;
    end else if (stage2_q.code == CODE_ZERO) begin
      pwm_d = 1'b0;
    end else if (stage2_q.code == CODE_FULL) begin
      pwm_d = 1'b1;
    end else if (prev_full_q && (pos < OVER_POS)) begin
      pwm_d = 1'b1;
    end else begin
      pwm_d = pulse_level(stage2_q, pos);
    end
  end
  // boundary pulses join since one register drives the pin with no gap.
  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      O_PWM <= 1'b0;
    end else begin
      O_PWM <= pwm_d;
    end
  end

  // Calibration: trims the ramp slope until full scale is reached within a period.
  pdpw_cal_t cal_q, cal_d;
  logic [4:0] div_q, div_d;
  logic [6:0] step_q, step_d;
  logic [SLOPE_W-1:0] slope_d;
  logic done_q, done_d;
  logic [11:0] dots_q, dots_d;
  logic ev_done, ev_timeout;
  always_comb begin
    cal_d = cal_q;
    div_d = div_q;
    step_d = step_q;
    slope_d = slope_q;
    done_d = done_q;
    dots_d = dots_q;
    ev_done = 1'b0;
    ev_timeout = 1'b0;
    if (cal_req) begin
      cal_d = CAL_HOLD;
      done_d = 1'b0;
      div_d = 5'h00;
      step_d = 7'h00;
      slope_d = SLOPE_MIN;
      dots_d = 12'h000;
    end else begin
      unique case (cal_q)
        CAL_IDLE: begin
        end
        CAL_HOLD: begin
          cal_d = CAL_RUN;
        end
        CAL_RUN: begin
          if (dot_edge) begin
            dots_d = dots_q + 12'h001;
            div_d = div_q + 5'h01;
            if (ramp_full) begin
              cal_d = CAL_IDLE;
              done_d = 1'b1;
              ev_done = 1'b1;
            end else if (div_q == CAL_DIV_LAST) begin
              step_d = step_q + 7'h01;
              slope_d = slope_q + SLOPE_STEP;
              // last step ends the run, so done never comes later than 32 x 64 dots.
              if (step_q == CAL_MAX_STEPS - 7'h01) begin
                cal_d = CAL_IDLE;
                done_d = 1'b1;
                ev_done = 1'b1;
                ev_timeout = 1'b1;
              end
            end
          end
        end
      endcase
    end
  end
  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      cal_q <= CAL_IDLE;
      div_q <= 5'h00;
      step_q <= 7'h00;
      slope_q <= SLOPE_NOM;
      done_q <= 1'b0;
      dots_q <= 12'h000;
      O_CAL_DONE <= 1'b0;
    end else begin
      cal_q <= cal_d;
      div_q <= div_d;
      step_q <= step_d;
      slope_q <= slope_d;
      done_q <= done_d;
      dots_q <= dots_d;
      O_CAL_DONE <= done_d;
    end
  end

  // AXI4-Lite slave; one write and one read in flight, unmapped offsets answer SLVERR.
  logic aw_got_q, aw_got_d, w_got_q, w_got_d;
  logic [AXI_AW-1:0] waddr_q, waddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic wlane_q, wlane_d;
  logic bvalid_d, awready_d, wready_d, arready_d, rvalid_d;
  logic [1:0] bresp_d, rresp_d;
  logic [31:0] rdata_d;
  logic [1:0] ctrl_d, int_stat_q, int_stat_d, int_en_q, int_en_d;
  logic wr_fire;
  logic [31:0] status;
  assign wr_fire = aw_got_q && w_got_q && !O_S_BVALID;
  always_comb begin
    status = 32'h0000_0000;
    status[ST_DONE] = done_q;
    status[ST_RUNNING] = (cal_q != CAL_IDLE);
    status[ST_PWR_OK] = pwr_ok;
    status[ST_STEP_LSB +: 7] = step_q;
    status[ST_SLOPE_LSB +: SLOPE_W] = slope_q;
  end
  always_comb begin
    aw_got_d = aw_got_q;
    w_got_d = w_got_q;
    waddr_d = waddr_q;
    wdata_d = wdata_q;
    wlane_d = wlane_q;
    bvalid_d = O_S_BVALID;
    bresp_d = O_S_BRESP;
    rvalid_d = O_S_RVALID;
    rdata_d = O_S_RDATA;
    rresp_d = O_S_RRESP;
    ctrl_d = ctrl_q;
    int_en_d = int_en_q;
    // Set wins over a clear that lands in the same cycle.
    int_stat_d = int_stat_q;
    if (I_S_AWVALID && O_S_AWREADY) begin
      aw_got_d = 1'b1;
      waddr_d = I_S_AWADDR;
    end
    if (I_S_WVALID && O_S_WREADY) begin
      w_got_d = 1'b1;
      wdata_d = I_S_WDATA;
      wlane_d = I_S_WSTRB[0];
    end
    if (O_S_BVALID && I_S_BREADY) begin
      bvalid_d = 1'b0;
    end
    if (wr_fire) begin
      aw_got_d = 1'b0;
      w_got_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = RESP_OKAY;
      unique case (waddr_q)
        REG_CTRL: if (wlane_q) ctrl_d = wdata_q[1:0];
        REG_INT_CLR: if (wlane_q) int_stat_d = int_stat_q & ~wdata_q[1:0];
        REG_INT_EN: if (wlane_q) int_en_d = wdata_q[1:0];
        REG_STATUS, REG_INT_STAT: begin
        end
        default: bresp_d = RESP_SLVERR;
      endcase
    end
    if (ev_done) begin
      int_stat_d[INT_DONE] = 1'b1;
    end
    if (ev_timeout) begin
      int_stat_d[INT_TIMEOUT] = 1'b1;
    end
    if (O_S_RVALID && I_S_RREADY) begin
      rvalid_d = 1'b0;
    end
    if (I_S_ARVALID && O_S_ARREADY) begin
      rvalid_d = 1'b1;
      rresp_d = RESP_OKAY;
      unique case (I_S_ARADDR)
        REG_CTRL: rdata_d = {30'h0000_0000, ctrl_q};
        REG_STATUS: rdata_d = status;
        REG_INT_STAT: rdata_d = {30'h0000_0000, int_stat_q};
        REG_INT_EN: rdata_d = {30'h0000_0000, int_en_q};
        REG_INT_CLR: rdata_d = 32'h0000_0000;
        default: begin
          rdata_d = 32'h0000_0000;
          rresp_d = RESP_SLVERR;
        end
      endcase
    end
    awready_d = !aw_got_d && !bvalid_d;
    wready_d = !w_got_d && !bvalid_d;
    arready_d = !rvalid_d;
  end
  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      waddr_q <= '0;
      wdata_q <= 32'h0000_0000;
      wlane_q <= 1'b0;
      O_S_BVALID <= 1'b0;
      O_S_BRESP <= RESP_OKAY;
      O_S_RVALID <= 1'b0;
      O_S_RDATA <= 32'h0000_0000;
      O_S_RRESP <= RESP_OKAY;
      O_S_AWREADY <= 1'b0;
      O_S_WREADY <= 1'b0;
      O_S_ARREADY <= 1'b0;
      ctrl_q <= CTRL_RESET;
      int_stat_q <= INT_RESET;
      int_en_q <= INT_RESET;
      O_IRQ <= 1'b0;
    end else begin
      aw_got_q <= aw_got_d;
      w_got_q <= w_got_d;
      waddr_q <= waddr_d;
      wdata_q <= wdata_d;
      wlane_q <= wlane_d;
      O_S_BVALID <= bvalid_d;
      O_S_BRESP <= bresp_d;
      O_S_RVALID <= rvalid_d;
      O_S_RDATA <= rdata_d;
      O_S_RRESP <= rresp_d;
      O_S_AWREADY <= awready_d;
      O_S_WREADY <= wready_d;
      O_S_ARREADY <= arready_d;
      ctrl_q <= ctrl_d;
      int_stat_q <= int_stat_d;
      int_en_q <= int_en_d;
      O_IRQ <= |(int_stat_d & int_en_d);
    end
  end

  // Checks on the behaviour above.
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_SYS_RST);

  cal_time_bound_a: assert property (dots_q <= CAL_MAX_DOTS)
    else $error("calibration ran past its step limit");
  power_low_a: assert property (!pwr_ok && !retrace |=> !O_PWM)
    else $error("output active during power reduce");
  code_capture_a: assert property (dot_edge |=> stage1_q == $past(in_dot))
    else $error("code not captured on dot edge");
  slave_stage_a: assert property (dot_edge |=> stage2_q == $past(stage1_q))
    else $error("second stage did not take first stage");
  zero_low_a: assert property (pwr_ok && !retrace && stage2_q.code == CODE_ZERO |=> !O_PWM)
    else $error("zero code produced high output");
  full_high_a: assert property (pwr_ok && stage2_q.code == CODE_FULL |=> O_PWM)
    else $error("full code produced low output");
  retrace_high_a: assert property (retrace |=> O_PWM)
    else $error("retrace did not force output high");
  cal_done_low_a: assert property (cal_req |=> !O_CAL_DONE)
    else $error("calibration done high during request");
  cal_step_pace_a: assert property ($changed(step_q) && !cal_req |-> $past(div_q) == CAL_DIV_LAST)
    else $error("trim stepped off the 32 dot pace");
  left_start_a: assert property (pwr_ok && !retrace && stage2_q.single && !stage2_q.lead
    && stage2_q.code != CODE_ZERO && pos == 8'h00 && !dot_edge |=> O_PWM)
    else $error("left pulse did not start at period start");

  cal_done_c: cover property (cal_q == CAL_RUN ##1 cal_q == CAL_IDLE && done_q);
  cal_timeout_c: cover property (ev_timeout);
  right_mode_c: cover property (stage2_q.single && stage2_q.lead && O_PWM);
  centre_mode_c: cover property (!stage2_q.single && O_PWM && pwr_ok);
endmodule : pdpw_top

// >>> testbench/pdpw_ctrl_model.sv
// Behavioural model of the printer controller that feeds dot codes and controls.
// Assumes it shares the system clock with the modulator and drives pins on its rising edge.
`timescale 1ns/100ps
module pdpw_ctrl_model import pdpw_pkg::*; (
  input wire logic i_clk, // System clock.
  input wire logic i_rst, // Reset, active high.
  input wire logic [9:0] i_half, // Half dot period in clocks.
  input wire pdpw_dot_t i_dot, // Value for even dots.
  input wire pdpw_dot_t i_dot_b, // Value for odd dots when alternating.
  input wire logic i_alt, // Alternate between the two values.
  input wire logic i_cal_start, // Starts a calibration request.
  output logic o_dot_clk, // Dot clock pin.
  output pdpw_dot_t o_dot, // Presented code and selects.
  output logic o_cal_req, // Calibration request pin.
  output logic [15:0] o_dots // Count of rising dot edges.
);
  logic [9:0] cnt_q;
  logic [8:0] cal_q;
  // Request lasts 260 clocks, longer than 1 us.
  assign o_cal_req = (cal_q != 9'h000);
  // Values change at the falling dot edge, stable around the rising one.
  // The dot clock never stops, as calibration needs it running.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_q <= 10'h000;
      o_dot_clk <= 1'b0;
      o_dot <= '0;
      o_dots <= 16'h0000;
      cal_q <= 9'h000;
    end else begin
      cal_q <= i_cal_start ? 9'h104 : cal_q - {8'h00, o_cal_req};
      if (cnt_q >= i_half - 10'h001) begin
        cnt_q <= 10'h000;
        o_dot_clk <= !o_dot_clk;
        if (o_dot_clk) o_dot <= (i_alt && o_dots[0]) ? i_dot_b : i_dot;
        else o_dots <= o_dots + 16'h0001;
      end else cnt_q <= cnt_q + 10'h001;
    end
  end
endmodule : pdpw_ctrl_model

// >>> testbench/tb.sv
// Self-checking bench for the modulator: register bus, widths, placement, merging, calibration.
// Assumes the controller model feeds the pins and the bench owns the bus and the loose inputs.
`timescale 1ns/100ps
module tb import pdpw_pkg::*; ;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [9:0] half = 10'h080;
  pdpw_dot_t dot_nx = '0;
  pdpw_dot_t dot_b = '0;
  pdpw_dot_t dot_pin;
  logic alt = 1'b0, cal_go = 1'b0, retrace = 1'b0, pwr_n = 1'b1;
  logic dot_clk, cal_req, pwm, cal_done, irq;
  logic [15:0] dots;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [AXI_AW-1:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata;
  logic [1:0] bresp, rresp;
  logic meas = 1'b0, pwm_prev = 1'b0;
  int hi_cnt = 0, rise_cnt = 0, n_errors = 0, checked = 0;
  logic [AXI_AW-1:0] ra [6] = '{REG_CTRL, REG_STATUS, REG_INT_STAT, REG_INT_CLR, REG_INT_EN, 5'h14};
  logic [31:0] rv [6] = '{32'h0, 32'h01000004, 32'h0, 32'h0, 32'h0, 32'h0};
  logic [7:0] codes [4] = '{8'h00, 8'h01, 8'h64, 8'hFF};

  // The system clock runs at 250 MHz.
  always #2 clk = !clk;

  pdpw_ctrl_model u_ctrl (.i_clk(clk), .i_rst(rst), .i_half(half), .i_dot(dot_nx),
    .i_dot_b(dot_b), .i_alt(alt), .i_cal_start(cal_go), .o_dot_clk(dot_clk), .o_dot(dot_pin),
    .o_cal_req(cal_req), .o_dots(dots));

  pdpw_top u_dut (.I_CLK(clk), .I_SYS_RST(rst), .I_DOT_CLK(dot_clk),
    .I_WIDTH_CODE_BITS(dot_pin.code), .I_SINGLE_OR_DUAL_EDGE_SELECT(dot_pin.single),
    .I_LEADING_OR_TRAILING_EDGE_SELECT(dot_pin.lead), .I_RETRACE(retrace),
    .I_POWER_REDUCE_N(pwr_n), .I_CAL_REQ(cal_req), .O_PWM(pwm), .O_CAL_DONE(cal_done),
    .O_IRQ(irq), .I_S_AWVALID(awvalid), .O_S_AWREADY(awready), .I_S_AWADDR(awaddr),
    .I_S_WVALID(wvalid), .O_S_WREADY(wready), .I_S_WDATA(wdata), .I_S_WSTRB(4'hF),
    .O_S_BVALID(bvalid), .I_S_BREADY(bready), .O_S_BRESP(bresp), .I_S_ARVALID(arvalid),
    .O_S_ARREADY(arready), .I_S_ARADDR(araddr), .O_S_RVALID(rvalid), .I_S_RREADY(rready),
    .O_S_RDATA(rdata), .O_S_RRESP(rresp));

  // High time and rising edges of the output are tallied while a window is open.
  always @(posedge clk) begin
    hi_cnt <= meas ? hi_cnt + int'(pwm === 1'b1) : 0;
    rise_cnt <= meas ? rise_cnt + int'(pwm === 1'b1 && pwm_prev !== 1'b1) : 0;
    pwm_prev <= pwm;
  end

  task automatic complete_run();
    if (n_errors == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
      n_errors++;
    end
  endtask : chk

  // A wait that runs out is reported as a mismatch and ends the run.
  task automatic hang();
    chk(32'h0, 32'h1);
    complete_run();
  endtask : hang

  task automatic wait_dots(input int n);
    int lim;
    logic [15:0] tgt;
    lim = 0;
    tgt = dots + 16'(n);
    while (dots !== tgt) begin
      @(posedge clk);
      lim++;
      if (lim > 700 * n) hang();
    end
  endtask : wait_dots

  task automatic axi_wr(input logic [AXI_AW-1:0] a, input logic [31:0] d, input logic [1:0] er);
    int lim;
    logic aw_p, w_p;
    lim = 0;
    aw_p = 1'b1;
    w_p = 1'b1;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      lim++;
      if (aw_p && awready === 1'b1) begin
        aw_p = 1'b0;
        awvalid <= 1'b0;
      end
      if (w_p && wready === 1'b1) begin
        w_p = 1'b0;
        wvalid <= 1'b0;
      end
      if (lim > 100) hang();
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er});
    @(posedge clk);
  endtask : axi_wr

  task automatic axi_rd(input logic [AXI_AW-1:0] a, input logic [31:0] exp,
                        input logic [31:0] mask, input logic [1:0] er);
    int lim;
    lim = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      lim++;
      if (arready === 1'b1) arvalid <= 1'b0;
      if (lim > 100) hang();
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk({30'h0, rresp}, {30'h0, er});
    chk(rdata & mask, exp);
    @(posedge clk);
  endtask : axi_rd

  task automatic window(input int n, output int hi, output int ri);
    meas <= 1'b1;
    repeat (n) @(posedge clk);
    meas <= 1'b0;
    #1;
    hi = hi_cnt;
    ri = rise_cnt;
    @(posedge clk);
  endtask : window

  // One value held for several dots, then high time counted from just after a dot edge.
  task automatic steady(input pdpw_dot_t d, input int len, input int exp, input int tol);
    int hi, ri;
    dot_nx <= d;
    wait_dots(4);
    window(len, hi, ri);
    if (hi >= exp - tol && hi <= exp + tol) hi = exp;
    chk(32'(hi), 32'(exp));
  endtask : steady

  // Two values alternate dot by dot; any 512-clock window sees one pair.
  task automatic pair(input pdpw_dot_t a, input pdpw_dot_t b, input int e_hi, input int e_ri);
    int hi, ri;
    dot_nx <= a;
    dot_b <= b;
    alt <= 1'b1;
    wait_dots(5);
    window(512, hi, ri);
    chk(32'(hi), 32'(e_hi));
    chk(32'(ri), 32'(e_ri));
    alt <= 1'b0;
  endtask : pair

  // Main sequence; calibration comes last since it retunes the ramp slope.
  initial begin
    int hi, ri, lim;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    chk({31'h0, cal_done}, 32'h0);
    for (int i = 0; i < 6; i++) axi_rd(ra[i], rv[i], '1, (i == 5) ? RESP_SLVERR : RESP_OKAY);
    axi_wr(5'h18, 32'h3, RESP_SLVERR);
    axi_wr(REG_STATUS, 32'hFFFFFFFF, RESP_OKAY);
    axi_rd(REG_CTRL, 32'h0, '1, RESP_OKAY);
    for (int m = 0; m < 4; m++) begin
      for (int c = 0; c < 4; c++) begin
        steady('{codes[c], m[1], m[0]}, 256, (c == 3) ? 256 : codes[c], 0);
      end
    end
    steady('{8'h80, 1'b1, 1'b0}, 128, 128, 8);
    steady('{8'h80, 1'b1, 1'b1}, 128, 0, 8);
    steady('{8'h80, 1'b0, 1'b1}, 128, 64, 8);
    pair('{8'h80, 1'b1, 1'b1}, '{8'h80, 1'b1, 1'b0}, 256, 1);
    // Left then centred pulses never touch, so each pair shows two separate rises.
    pair('{8'h80, 1'b1, 1'b0}, '{8'h40, 1'b0, 1'b0}, 192, 2);
    pair('{8'hFF, 1'b1, 1'b0}, '{8'h80, 1'b1, 1'b1}, 389, 1);
    steady('{8'h00, 1'b1, 1'b0}, 256, 0, 0);
    wait_dots(1);
    dot_nx <= '{8'hFF, 1'b1, 1'b0};
    wait_dots(1);
    repeat (8) @(posedge clk);
    window(200, hi, ri);
    chk(32'(hi), 32'h0);
    wait_dots(1);
    repeat (8) @(posedge clk);
    window(200, hi, ri);
    chk(32'(hi), 32'd200);
    retrace <= 1'b1;
    steady('{8'h00, 1'b1, 1'b0}, 256, 256, 0);
    retrace <= 1'b0;
    steady('{8'h00, 1'b1, 1'b0}, 256, 0, 0);
    axi_wr(REG_CTRL, 32'h1, RESP_OKAY);
    steady('{8'h00, 1'b1, 1'b0}, 256, 256, 0);
    axi_wr(REG_CTRL, 32'h2, RESP_OKAY);
    axi_rd(REG_STATUS, 32'h0, 32'h4, RESP_OKAY);
    axi_wr(REG_CTRL, 32'h0, RESP_OKAY);
    pwr_n <= 1'b0;
    steady('{8'h80, 1'b1, 1'b0}, 256, 0, 0);
    axi_rd(REG_STATUS, 32'h0, 32'h4, RESP_OKAY);
    pwr_n <= 1'b1;
    axi_wr(REG_INT_EN, 32'h1, RESP_OKAY);
    // A 500-clock dot period is too short for the slowest slope, so one trim step is needed.
    half <= 10'h0FA;
    dot_nx <= '0;
    wait_dots(2);
    cal_go <= 1'b1;
    @(posedge clk);
    cal_go <= 1'b0;
    repeat (20) @(posedge clk);
    chk({31'h0, cal_done}, 32'h0);
    lim = 0;
    while (cal_done !== 1'b1) begin
      @(posedge clk);
      lim++;
      if (lim > 20000) hang();
    end
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    axi_rd(REG_INT_STAT, 32'h1, 32'h3, RESP_OKAY);
    // Done, power ok, one step taken, slope one step above its minimum.
    axi_rd(REG_STATUS, 32'h0084_0105, 32'h0FFF_7F07, RESP_OKAY);
    axi_wr(REG_INT_EN, 32'h0, RESP_OKAY);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    axi_wr(REG_INT_EN, 32'h1, RESP_OKAY);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    axi_wr(REG_INT_CLR, 32'h1, RESP_OKAY);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    axi_rd(REG_INT_STAT, 32'h0, 32'h3, RESP_OKAY);
    cal_go <= 1'b1;
    @(posedge clk);
    cal_go <= 1'b0;
    repeat (20) @(posedge clk);
    chk({31'h0, cal_done}, 32'h0);
    complete_run();
  end
endmodule : tb
